/* File: core/reset_cause_and_release_sequencer.sv */
`timescale 1ns/1ps
// How it works
// - Brown-out reset sets flag bit 1; no other hardware clears it.
// - Power-on reset sets flag bit 0; no other hardware clears it.
// - Software may set or clear every flag without causing a reset.
// - Fuse enable at one keeps the watchdog running regardless of software enable.
// - Cause flags set by their events, cleared by power-on or brown-out; pin flag by power-on.
// - Watchdog timeout flag cleared by power-save, watchdog clear, power-on, brown-out.
// - With switching, power-on and brown-out load initial select; others keep current.
// - Without switching, reset always loads the configured oscillator select.
// - Release waits power-on, start-up and internal reset times as applicable.
// - Power-on delay of 10 us applies only to power-on reset.
// - Start-up 20 us with regulator, 64 ms timer without; the 20 us also on wake.
// - Every reset includes 20 us internal time; simple resets use only it.
// - Crystal sources wait 1024 oscillator periods on a 10-bit counter.
// - PLL sources additionally wait 20 us lock time.
// - Oscillator waits run alongside the release delays.
// - Code may not run until a valid clock is released.
// - Monitor finding no valid clock switches to fast RC and traps.
// - Crystal or PLL sources start the monitor after a 500 us delay.
// - Only the flag, oscillator and status registers depend on reset type.
module reset_cause_and_release_sequencer #(
	parameter int POWER_UP_TIMER_CYCLES = rst_seq_pkg::CYC_POWER_UP_TIMER
)
(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input rst_seq_pkg::events_s ev,
	input wire logic wake,
	input wire logic clock_switch_en,
	input wire logic regulator_en,
	input wire logic watchdog_fuse_enable,
	input wire logic monitor_en,
	input wire logic [2:0] initial_osc_select,
	input wire logic osc_is_crystal,
	input wire logic osc_is_pll,
	input wire logic osc_tick,
	input wire logic osc_running,
	output logic system_reset_signal,
	output logic cpu_run,
	output logic watchdog_run,
	output logic [2:0] current_osc_select,
	output logic osc_fail_trap,
	output logic irq
);
	rst_seq_pkg::reset_kind_e kind_q;
	typedef enum {ST_IDLE, ST_DELAY, ST_MONWAIT, ST_RUN} seq_e;
	seq_e st_q;
	logic [15:0] flags_q;
	logic [2:0] current_osc_select_q;
	logic [9:0] ost_q;
	logic ost_done_q, lock_done_q, clk_valid_q, system_reset_signal_q, trap_q, run_q, wdt_q;
	logic [rst_seq_pkg::IRQ_BITS-1:0] ista_q, imask_q, iev;
	logic [15:0] rdata_q;
	logic irq_q, load_rel, load_lock, rel_done, lock_done, mon_done;
	logic any_rst;
	logic [23:0] rel_cnt;

	assign any_rst = ev.por | ev.bor | ev.pin | ev.wdt | ev.sw | ev.iop | ev.trap;

	function automatic logic [23:0] cyc(input int n);
		cyc = n[23:0];
	endfunction : cyc

	// Release delay per reset kind.
	always_comb
	begin
		rel_cnt = cyc(rst_seq_pkg::CYC_RST);
		if (ev.por)
			rel_cnt = cyc(rst_seq_pkg::CYC_POR + rst_seq_pkg::CYC_RST
				+ (regulator_en ? rst_seq_pkg::CYC_STARTUP : POWER_UP_TIMER_CYCLES));
		else if (ev.bor)
			rel_cnt = cyc(rst_seq_pkg::CYC_RST
				+ (regulator_en ? rst_seq_pkg::CYC_STARTUP : POWER_UP_TIMER_CYCLES));
		else if (wake && regulator_en)
			rel_cnt = cyc(rst_seq_pkg::CYC_STARTUP);
	end

	// With the regulator off a wake has no start-up delay, so it does not hold reset.
	assign load_rel = any_rst | (wake && regulator_en && st_q == ST_RUN);
	assign load_lock = (ev.por | ev.bor) & osc_is_pll;

	rst_delay_counter u_rel (.clk(core_clk), .rst(sys_rst), .load(load_rel),
		.count(rel_cnt), .done(rel_done));
	rst_delay_counter u_lock (.clk(core_clk), .rst(sys_rst), .load(load_lock),
		.count(cyc(rst_seq_pkg::CYC_LOCK)), .done(lock_done));
	// The longer monitor delay is used, which gives slow crystals more time to settle.
	rst_delay_counter u_mon (.clk(core_clk), .rst(sys_rst),
		.load(st_q == ST_DELAY && rel_done), .count(cyc(rst_seq_pkg::CYC_CLOCK_FAIL_MONITOR)),
		.done(mon_done));

	// Reset-cause flags; hardware set wins over a software write.
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			flags_q <= rst_seq_pkg::FLAGS_POR_VAL;
		else
		begin
			logic [15:0] f;
			f = flags_q;
			if (reg_wr && reg_addr == rst_seq_pkg::OFS_FLAGS)
				f = reg_wdata & rst_seq_pkg::FLAGS_MASK;
			if (ev.por)
				f = f & rst_seq_pkg::FLAGS_POR_KEEP;
			else if (ev.bor)
				f = f & rst_seq_pkg::FLAGS_BOR_KEEP;
			if (ev.wdt_clear || ev.sleep || ev.idle)
				f[rst_seq_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
			f[rst_seq_pkg::BIT_POR] = f[rst_seq_pkg::BIT_POR] | ev.por;
			f[rst_seq_pkg::BIT_BOR] = f[rst_seq_pkg::BIT_BOR] | ev.bor;
			f[rst_seq_pkg::BIT_EXT_PIN_RESET_FLAG] = f[rst_seq_pkg::BIT_EXT_PIN_RESET_FLAG] | ev.pin;
			f[rst_seq_pkg::BIT_SWR] = f[rst_seq_pkg::BIT_SWR] | ev.sw;
			f[rst_seq_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = f[rst_seq_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] | ev.wdt;
			f[rst_seq_pkg::BIT_SLEEP] = f[rst_seq_pkg::BIT_SLEEP] | ev.sleep;
			f[rst_seq_pkg::BIT_IDLE] = f[rst_seq_pkg::BIT_IDLE] | ev.idle;
			f[rst_seq_pkg::BIT_CM] = f[rst_seq_pkg::BIT_CM] | ev.cm;
			f[rst_seq_pkg::BIT_IOP] = f[rst_seq_pkg::BIT_IOP] | ev.iop;
			f[rst_seq_pkg::BIT_TRAP] = f[rst_seq_pkg::BIT_TRAP] | ev.trap;
			flags_q <= f;
		end
	end

	// Oscillator select chosen by reset kind; other registers apart from flags and status are plain.
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			current_osc_select_q <= rst_seq_pkg::FRC_SEL;
		else if ((ev.por || ev.bor) || (any_rst && !clock_switch_en))
			current_osc_select_q <= initial_osc_select;
		else if (!any_rst && trap_q == 1'b0 && st_q == ST_MONWAIT && mon_done && monitor_en
			&& !clk_valid_q)
			current_osc_select_q <= rst_seq_pkg::FRC_SEL;
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			kind_q <= rst_seq_pkg::RT_NONE;
		else if (ev.por)
			kind_q <= rst_seq_pkg::RT_POR;
		else if (ev.bor)
			kind_q <= rst_seq_pkg::RT_BOR;
		else if (any_rst)
			kind_q <= rst_seq_pkg::RT_PIN;
	end

	// Oscillator start-up on a 10-bit counter, in parallel with release.
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ost_q <= 10'h3FF;
			ost_done_q <= 1'b0;
		end
		else if (ev.por || ev.bor)
		begin
			ost_q <= 10'h3FF;
			ost_done_q <= !osc_is_crystal;
		end
		// A dead crystal never finishes here; the monitor is what catches that case.
		else if (!ost_done_q && osc_tick && osc_running)
		begin
			ost_q <= ost_q - 10'h001;
			if (ost_q == 10'h000)
				ost_done_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			lock_done_q <= 1'b0;
		else if (ev.por || ev.bor)
			lock_done_q <= !osc_is_pll;
		else if (lock_done)
			lock_done_q <= 1'b1;
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			clk_valid_q <= 1'b0;
		else
			clk_valid_q <= ost_done_q && lock_done_q && !(ev.por || ev.bor);
	end

	// Release sequence.
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			st_q <= ST_IDLE;
		else if (load_rel)
			st_q <= ST_DELAY;
		else
			case (st_q)
				ST_IDLE: st_q <= ST_IDLE;
				ST_DELAY:
					if (rel_done)
						st_q <= (osc_is_crystal || osc_is_pll) ? ST_MONWAIT : ST_RUN;
				ST_MONWAIT:
					if (mon_done)
						st_q <= ST_RUN;
				ST_RUN: st_q <= ST_RUN;
				default: st_q <= ST_IDLE;
			endcase
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			system_reset_signal_q <= 1'b1;
			run_q <= 1'b0;
			trap_q <= 1'b0;
		end
		else
		begin
			system_reset_signal_q <= load_rel || st_q == ST_IDLE || (st_q == ST_DELAY && !rel_done);
			run_q <= !load_rel && st_q != ST_IDLE && !(st_q == ST_DELAY && !rel_done)
				&& (clk_valid_q || trap_q);
			if (any_rst)
				trap_q <= 1'b0;
			else if (st_q == ST_MONWAIT && mon_done && monitor_en && !clk_valid_q)
				trap_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			wdt_q <= 1'b0;
		else
			wdt_q <= watchdog_fuse_enable || flags_q[rst_seq_pkg::BIT_WATCHDOG_SOFT_ENABLE];
	end

	// Interrupt status: sticky, write one to clear, set wins.
	assign iev = {st_q == ST_MONWAIT && mon_done && monitor_en && !clk_valid_q && !trap_q,
		clk_valid_q == 1'b0 && ost_done_q && lock_done_q,
		st_q == ST_DELAY && rel_done};

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ista_q <= 3'h0;
			imask_q <= 3'h0;
		end
		else
		begin
			if (reg_wr && reg_addr == rst_seq_pkg::OFS_IRQ_STAT)
				ista_q <= (ista_q & ~reg_wdata[2:0]) | iev;
			else
				ista_q <= ista_q | iev;
			if (reg_wr && reg_addr == rst_seq_pkg::OFS_IRQ_MASK)
				imask_q <= reg_wdata[2:0];
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			irq_q <= 1'b0;
		else
			irq_q <= |(ista_q & imask_q);
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			rdata_q <= 16'h0000;
		else if (reg_rd)
			case (reg_addr)
				rst_seq_pkg::OFS_FLAGS: rdata_q <= flags_q;
				rst_seq_pkg::OFS_OSC: rdata_q <= {13'h0, current_osc_select_q};
				rst_seq_pkg::OFS_IRQ_STAT: rdata_q <= {13'h0, ista_q};
				rst_seq_pkg::OFS_IRQ_MASK: rdata_q <= {13'h0, imask_q};
				// Power-on and brown-out show their own kind and every other reset shows RT_PIN, so software can tell which delays applied.
				rst_seq_pkg::OFS_STATUS:
					rdata_q <= {9'h000, kind_q, trap_q, clk_valid_q, run_q, system_reset_signal_q};
				default: rdata_q <= 16'h0000;
			endcase
		else
			rdata_q <= 16'h0000;
	end

	assign reg_rdata = rdata_q;
	assign system_reset_signal = system_reset_signal_q;
	assign cpu_run = run_q;
	assign watchdog_run = wdt_q;
	assign current_osc_select = current_osc_select_q;
	assign osc_fail_trap = trap_q;
	assign irq = irq_q;

	// Some flag checks leave out same-cycle software writes, which may legally clear a flag that brown-out keeps.
	logic flag_wr;
	assign flag_wr = reg_wr && reg_addr == rst_seq_pkg::OFS_FLAGS;

	chk_por_flag_set: assert property (@(posedge core_clk) disable iff (sys_rst)
		ev.por |=> flags_q[rst_seq_pkg::BIT_POR])
		else $error("power-on flag not set");
	chk_bor_flag_set: assert property (@(posedge core_clk) disable iff (sys_rst)
		ev.bor |=> flags_q[rst_seq_pkg::BIT_BOR])
		else $error("brown-out flag not set");
	chk_pin_flag_kept: assert property (@(posedge core_clk) disable iff (sys_rst)
		ev.bor && flags_q[rst_seq_pkg::BIT_EXT_PIN_RESET_FLAG] && !flag_wr |=> flags_q[rst_seq_pkg::BIT_EXT_PIN_RESET_FLAG])
		else $error("pin flag lost on brown-out");
	chk_watchdog_timeout_flag_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
		ev.wdt_clear && !ev.wdt && !flag_wr |=> !flags_q[rst_seq_pkg::BIT_WATCHDOG_TIMEOUT_FLAG])
		else $error("timeout flag not cleared");
	chk_sw_write_safe: assert property (@(posedge core_clk) disable iff (sys_rst)
		reg_wr && !any_rst && !wake && st_q == ST_RUN |=> !system_reset_signal_q)
		else $error("write caused reset");
	chk_wdt_fuse_run: assert property (@(posedge core_clk) disable iff (sys_rst)
		watchdog_fuse_enable |=> wdt_q)
		else $error("watchdog not running");
	chk_osc_por_sel: assert property (@(posedge core_clk) disable iff (sys_rst)
		ev.por && !osc_is_pll |=> current_osc_select_q == $past(initial_osc_select))
		else $error("osc select wrong");
	chk_run_needs_clk: assert property (@(posedge core_clk) disable iff (sys_rst)
		run_q |-> $past(clk_valid_q) || $past(trap_q))
		else $error("ran without clock");
	chk_rst_min_time: assert property (@(posedge core_clk) disable iff (sys_rst)
		ev.pin && !ev.por && !ev.bor |=> system_reset_signal_q [*8])
		else $error("release too early");
	chk_trap_frc: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(trap_q) |-> current_osc_select_q == rst_seq_pkg::FRC_SEL)
		else $error("trap without rc");
	chk_por_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
		ev.por |=> system_reset_signal_q [*8])
		else $error("power-on release too early");
	chk_bor_keeps_por: assert property (@(posedge core_clk) disable iff (sys_rst)
		ev.bor && flags_q[rst_seq_pkg::BIT_POR] && !flag_wr |=> flags_q[rst_seq_pkg::BIT_POR])
		else $error("power-on flag lost");
	chk_por_clears: assert property (@(posedge core_clk) disable iff (sys_rst)
		ev == rst_seq_pkg::events_s'(11'h400) && !flag_wr |=> (flags_q & 16'hFFFC) == 16'h0000)
		else $error("cause flags kept on power-on");
	chk_pll_lock_wait: assert property (@(posedge core_clk) disable iff (sys_rst)
		ev.por && osc_is_pll |=> !clk_valid_q [*8])
		else $error("clock valid before lock");
	chk_wake_delay: assert property (@(posedge core_clk) disable iff (sys_rst)
		wake && regulator_en && st_q == ST_RUN |=> system_reset_signal_q [*8])
		else $error("wake without start-up delay");
	chk_trap_after_rel: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(trap_q) |-> !system_reset_signal_q)
		else $error("monitor ran during reset");
	chk_irq_level: assert property (@(posedge core_clk) disable iff (sys_rst)
		|(ista_q & imask_q) |=> irq_q)
		else $error("interrupt not raised");

	cov_por_run: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(run_q));
	cov_trap: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(trap_q));
	cov_irq: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(irq_q));
	cov_pll_start: cover property (@(posedge core_clk) disable iff (sys_rst) ev.por && osc_is_pll);
	cov_wake_start: cover property (@(posedge core_clk) disable iff (sys_rst)
		wake && regulator_en && st_q == ST_RUN);
endmodule : reset_cause_and_release_sequencer

/* File: core/rst_delay_counter.sv */
`timescale 1ns/1ps
// Loadable down-counter; done is high while idle at zero after a load.
module rst_delay_counter
(
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [23:0] count,
	output logic done
);
	logic [23:0] cnt_q;
	logic run_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q <= 24'h00_0000;
			run_q <= 1'b0;
		end
		else if (load)
		begin
			cnt_q <= count;
			run_q <= 1'b1;
		end
		else if (cnt_q != 24'h00_0000)
			cnt_q <= cnt_q - 24'h00_0001;
	end

	assign done = run_q && (cnt_q == 24'h00_0000) && !load;
endmodule : rst_delay_counter

/* File: core/rst_seq_pkg.sv */
package rst_seq_pkg;

	// Reset-cause flag positions.
	localparam int BIT_POR = 0;
	localparam int BIT_BOR = 1;
	localparam int BIT_IDLE = 2;
	localparam int BIT_SLEEP = 3;
	localparam int BIT_WATCHDOG_TIMEOUT_FLAG = 4;
	localparam int BIT_WATCHDOG_SOFT_ENABLE = 5;
	localparam int BIT_SWR = 6;
	localparam int BIT_EXT_PIN_RESET_FLAG = 7;
	localparam int BIT_CM = 9;
	localparam int BIT_IOP = 14;
	localparam int BIT_TRAP = 15;
	localparam logic [15:0] FLAGS_MASK = 16'hC2FF;
	localparam logic [15:0] FLAGS_POR_VAL = 16'h0001;
	// Power-on keeps only the brown-out flag; the soft enable returns to its reset value.
	localparam logic [15:0] FLAGS_POR_KEEP = 16'h0002;
	localparam logic [15:0] FLAGS_BOR_KEEP = 16'h00A3;

	// Register offsets on the plain port.
	localparam logic [3:0] OFS_FLAGS = 4'h0;
	localparam logic [3:0] OFS_OSC = 4'h1;
	localparam logic [3:0] OFS_IRQ_STAT = 4'h2;
	localparam logic [3:0] OFS_IRQ_MASK = 4'h3;
	localparam logic [3:0] OFS_STATUS = 4'h4;

	// Interrupt status bits.
	localparam int IRQ_RELEASE = 0;
	localparam int IRQ_CLK_VALID = 1;
	localparam int IRQ_OSC_FAIL = 2;
	localparam int IRQ_BITS = 3;

	localparam logic [2:0] FRC_SEL = 3'h0;

	// Times and cycle counts at 20 MHz.
	localparam int CLK_MHZ = 20;
	localparam int T_POR_US = 10;
	localparam int T_STARTUP_US = 20;
	localparam int T_POWER_UP_TIMER_MS = 64;
	localparam int T_RST_US = 20;
	localparam int T_LOCK_US = 20;
	localparam int T_CLOCK_FAIL_MONITOR_US = 500;
	localparam int OST_PERIODS = 1024;
	localparam int CYC_POR = T_POR_US * CLK_MHZ;
	localparam int CYC_STARTUP = T_STARTUP_US * CLK_MHZ;
	localparam int CYC_POWER_UP_TIMER = T_POWER_UP_TIMER_MS * 1000 * CLK_MHZ;
	localparam int CYC_RST = T_RST_US * CLK_MHZ;
	localparam int CYC_LOCK = T_LOCK_US * CLK_MHZ;
	localparam int CYC_CLOCK_FAIL_MONITOR = T_CLOCK_FAIL_MONITOR_US * CLK_MHZ;

	typedef enum logic [2:0] {RT_NONE, RT_POR, RT_BOR, RT_PIN, RT_WDT, RT_SW, RT_IOP, RT_TRAP}
		reset_kind_e;

	typedef struct packed {
		logic por;
		logic bor;
		logic pin;
		logic wdt;
		logic sw;
		logic iop;
		logic trap;
		logic cm;
		logic sleep;
		logic idle;
		logic wdt_clear;
	} events_s;

	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} bus_req_s;

endpackage : rst_seq_pkg

/* File: tb/osc_partner.sv */
`timescale 1ns/1ps
// Oscillator stand-in: one tick every period cycles while running.
// A stopped oscillator gives no ticks at all, as a dead crystal would.
module osc_partner
(
	input wire logic core_clk,
	input wire logic run,
	input wire logic [7:0] period,
	output logic osc_tick,
	output logic osc_running
);
	logic [7:0] cnt_q;

	always_ff @(posedge core_clk)
	begin
		cnt_q <= (!run || cnt_q >= period - 8'h01) ? 8'h00 : cnt_q + 8'h01;
		osc_tick <= run && cnt_q == 8'h00;
	end

	assign osc_running = run;
endmodule : osc_partner

/* File: tb/reset_cause_and_release_sequencer_tb.sv */
`timescale 1ns/1ps
module reset_cause_and_release_sequencer_tb;
	// A short power-up timer keeps the run brief; expectations use it.
	localparam int POWER_UP_TIMER = 100;
	localparam int T_POR = rst_seq_pkg::CYC_POR;
	localparam int T_UP = rst_seq_pkg::CYC_STARTUP;
	localparam int T_RST = rst_seq_pkg::CYC_RST;
	localparam int T_MON = rst_seq_pkg::CYC_CLOCK_FAIL_MONITOR;
	localparam logic [3:0] A_FL = rst_seq_pkg::OFS_FLAGS;
	localparam logic [3:0] A_ST = rst_seq_pkg::OFS_IRQ_STAT;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic clock_switch_en = 1'b1;
	logic regulator_en = 1'b1;
	logic watchdog_fuse_enable = 1'b0;
	logic monitor_en = 1'b0;
	logic [2:0] initial_osc_select = 3'h0;
	logic osc_is_crystal = 1'b0;
	logic osc_run = 1'b0;
	logic wake = 1'b0;
	logic osc_is_pll = 1'b0;
	rst_seq_pkg::events_s ev = '0;
	logic [15:0] reg_rdata;
	logic [2:0] current_osc_select;
	logic [2:0] sel0;
	logic osc_tick, osc_running, system_reset_signal, cpu_run, watchdog_run, osc_fail_trap, irq;
	int error_cnt = 0;
	int n_tests = 0;
	int fm = 1;
	int ticks = 0;
	int c;
	// Flag bit set by each event, indexed by its place in the event struct.
	int fbit[11] = '{0, 2, 3, 9, 15, 14, 6, 4, 7, 1, 0};

	reset_cause_and_release_sequencer #(.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER)) i_dut (.core_clk, .sys_rst,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ev, .wake,
		.clock_switch_en, .regulator_en, .watchdog_fuse_enable, .monitor_en,
		.initial_osc_select, .osc_is_crystal, .osc_is_pll, .osc_tick, .osc_running,
		.system_reset_signal, .cpu_run, .watchdog_run, .current_osc_select, .osc_fail_trap,
		.irq);

	osc_partner i_osc (.core_clk, .run(osc_run), .period(8'h04), .osc_tick, .osc_running);

	initial
	begin
		forever #25 core_clk = ~core_clk;
	end

	always @(posedge core_clk)
	begin
		if (osc_tick === 1'b1)
			ticks++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rdc(input logic [3:0] a, input int exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : rdc

	task automatic gap();
		repeat (2) @(posedge core_clk);
		#1;
	endtask : gap

	// Reference flag model: each event updates it as the hardware should.
	task automatic pulse(input int i);
		@(posedge core_clk);
		ev <= rst_seq_pkg::events_s'(11'h001 << i);
		@(posedge core_clk);
		ev <= '0;
		if (i == 10)
			fm = fm & 2 | 1;
		else if (i == 9)
			fm = fm & 32'hA3 | 2;
		else if (i < 3)
			fm = fm & ~32'h10 | (i > 0 ? 1 << fbit[i] : 0);
		else
			fm = fm | 1 << fbit[i];
	endtask : pulse

	// An expected count of zero only needs release within 2000 cycles; others must land within a few cycles.
	task automatic wait_rel(input int exp);
		@(posedge core_clk);
		#1;
		c = 1;
		while (system_reset_signal !== 1'b0 && c < exp + 2000)
		begin
			@(posedge core_clk);
			c++;
		end
		chk((c > exp - 4 && c < exp + 9) || (exp == 0 && c < 2000) ? exp : c, exp);
	endtask : wait_rel

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	initial
	begin
		void'($urandom(10));
		initial_osc_select = 3'($urandom);
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'b0;
		rdc(A_FL, 1);
		rdc(4'hF, 0);
		pulse(10);
		wait_rel(T_POR + T_UP + T_RST);
		rdc(A_FL, fm);
		sel0 = initial_osc_select;
		chk(current_osc_select, sel0);
		initial_osc_select <= sel0 ^ 3'(1 + $urandom % 7);
		for (int i = 8; i > 0; i--)
		begin
			pulse(i);
			if (i > 3)
				wait_rel(T_RST);
			else
				wait_rel(0);
			rdc(A_FL, fm);
		end
		chk(current_osc_select, sel0);
		pulse(0);
		wait_rel(0);
		rdc(A_FL, fm);
		@(posedge core_clk);
		wake <= 1'b1;
		@(posedge core_clk);
		wake <= 1'b0;
		wait_rel(T_UP);
		regulator_en <= 1'b0;
		pulse(9);
		wait_rel(POWER_UP_TIMER + T_RST);
		rdc(A_FL, fm);
		pulse(10);
		wait_rel(T_POR + POWER_UP_TIMER + T_RST);
		rdc(A_FL, fm);
		regulator_en <= 1'b1;
		c = $urandom & 16'hFFFF | 16'h0020;
		wr(A_FL, 16'(c));
		fm = c & rst_seq_pkg::FLAGS_MASK;
		gap();
		chk(system_reset_signal, 0);
		chk(watchdog_run, 1);
		rdc(A_FL, fm);
		fm = fm & 16'hFFDF;
		wr(A_FL, 16'(fm));
		gap();
		chk(watchdog_run, 0);
		watchdog_fuse_enable <= 1'b1;
		gap();
		chk(watchdog_run, 1);
		clock_switch_en <= 1'b0;
		initial_osc_select <= sel0 ^ 3'(1 + $urandom % 7);
		pulse(8);
		wait_rel(T_RST);
		chk(current_osc_select, initial_osc_select);
		osc_is_pll <= 1'b1;
		pulse(10);
		rdc(rst_seq_pkg::OFS_STATUS, int'(rst_seq_pkg::RT_POR) * 16 + 1);
		wait_rel(T_POR + T_UP + T_RST);
		rdc(rst_seq_pkg::OFS_STATUS, int'(rst_seq_pkg::RT_POR) * 16 + 6);
		osc_is_pll <= 1'b0;
		clock_switch_en <= 1'b1;
		osc_is_crystal <= 1'b1;
		monitor_en <= 1'b1;
		osc_run <= 1'b1;
		pulse(10);
		ticks = 0;
		wait_rel(T_POR + T_UP + T_RST);
		chk(cpu_run, 0);
		c = 0;
		while (cpu_run !== 1'b1 && c < 20000)
		begin
			@(posedge core_clk);
			c++;
		end
		chk(cpu_run, 1);
		chk(ticks >= 1024 ? 1 : ticks, 1);
		chk(osc_fail_trap, 0);
		wr(A_ST, 16'h0007);
		osc_run <= 1'b0;
		initial_osc_select <= 3'h1 | 3'($urandom);
		pulse(10);
		wait_rel(T_POR + T_UP + T_RST);
		chk(current_osc_select, initial_osc_select);
		chk(osc_fail_trap, 0);
		c = 0;
		while (osc_fail_trap !== 1'b1 && c < T_MON + 2000)
		begin
			@(posedge core_clk);
			c++;
		end
		chk(c > T_MON - 5 && c < T_MON + 20 ? T_MON : c, T_MON);
		chk(current_osc_select, rst_seq_pkg::FRC_SEL);
		rdc(A_ST, 5);
		chk(irq, 0);
		wr(rst_seq_pkg::OFS_IRQ_MASK, 16'h0004);
		gap();
		chk(irq, 1);
		wr(A_ST, 16'h0004);
		gap();
		chk(irq, 0);
		print_verdict();
	end
endmodule : reset_cause_and_release_sequencer_tb
